// file: src/rtc_flag.sv
// sticky status flag, a set in the clearing cycle wins
`timescale 1ns/1ns
module rtc_flag #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_set,
   input  wire logic i_clr,
   output logic      o_flag
);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_flag <= RST_VAL;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clr) begin
         o_flag <= 1'b0;
      end
   end
endmodule

// file: src/rtc_irq_timer.sv
// rtc interrupt, timer, oscillator stop and counter access logic
`timescale 1ns/1ns
module rtc_irq_timer #(
   parameter int unsigned OSC_STOP_CYC = rtc_pkg::OSC_STOP_CYC,
   parameter int unsigned GAP_W        = 24
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst,
   input  wire logic            i_xtal,
   input  wire logic            i_alarm_enable_bit,
   input  wire rtc_pkg::rtc_hm_t i_alarm_time,
   input  wire rtc_pkg::rtc_hm_t i_cur_time,
   input  wire logic            i_alarm_flag_clear,
   input  wire logic [2:0]      i_cyclic_sel,
   input  wire logic            i_cyclic_level_mode_bit,
   input  wire logic            i_cyclic_flag_clear,
   input  wire logic [2:0]      i_timer_period_select,
   input  wire logic            i_timer_restart_bit,
   input  wire logic            i_seconds_adjust_bit,
   input  wire logic            i_count_enable_bit,
   input  wire logic            i_osc_flag_clear,
   output logic                 o_irq_out_n,
   output logic                 o_irq_oe_n,
   output logic                 o_alarm_flag,
   output logic                 o_cyclic_flag,
   output logic                 o_timer_pulse_out,
   output logic                 o_timer_flag,
   output logic                 o_osc_stop_flag,
   output logic                 o_carry_busy_flag,
   output logic                 o_sec_carry,
   output logic                 o_adjust_round_up
);

   // crystal time base
   logic                 xt_sync;
   logic                 xt_prev;
   logic [14:0]          pre;
   logic [5:0]           sec_cnt;
   logic [GAP_W-1:0]     gap_cnt;
   rtc_pkg::rtc_adj_t    adj_state;
   logic [2:0]           adj_cnt;
   logic                 carry_win;
   logic                 match_d;
   logic [15:0]          tmr_cnt;
   logic [3:0]           tmr_pulse_cnt;

   wire xt_tick  = xt_sync & ~xt_prev;
   wire adj_busy = (adj_state == rtc_pkg::ADJ_BUSY);
   wire tick_run = xt_tick & ~adj_busy;
   wire adj_start = (adj_state == rtc_pkg::ADJ_IDLE) & i_seconds_adjust_bit;
   wire sec_wrap = tick_run & (pre == rtc_pkg::MASK_1S);
   wire sec_last = (sec_cnt == 6'(rtc_pkg::SEC_PER_MIN - 1));
   wire sec_mid  = (sec_cnt == 6'(rtc_pkg::SEC_HALF_MIN - 1));

   rtc_sync3 u_xt_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_xtal),
      .o_sync  (xt_sync)
   );

   // cyclic period decode
   wire [14:0] cyc_mask =
      (i_cyclic_sel == rtc_pkg::CYC_488US) ? rtc_pkg::MASK_488US :
      (i_cyclic_sel == rtc_pkg::CYC_977US) ? rtc_pkg::MASK_977US :
      (i_cyclic_sel == rtc_pkg::CYC_7MS)   ? rtc_pkg::MASK_7MS   :
      (i_cyclic_sel == rtc_pkg::CYC_62MS)  ? rtc_pkg::MASK_62MS  :
      rtc_pkg::MASK_1S;
   wire cyc_is_min = (i_cyclic_sel == rtc_pkg::CYC_60S);
   wire cyc_on     = (i_cyclic_sel != rtc_pkg::CYC_OFF) &
                     (i_cyclic_sel <= rtc_pkg::CYC_60S);
   wire cyc_bnd_sub = tick_run & ((pre & cyc_mask) == cyc_mask);
   wire cyc_half_sub = tick_run & ((pre & cyc_mask) == (cyc_mask >> 1));
   wire cyc_bnd  = cyc_on & (cyc_is_min ? (sec_wrap & sec_last) : cyc_bnd_sub);
   wire cyc_half = cyc_is_min ? (sec_wrap & sec_mid) : cyc_half_sub;
   wire cyc_long = (i_cyclic_sel == rtc_pkg::CYC_1S) | cyc_is_min;
   wire cyc_adj_rel = adj_start & cyc_long & ~i_cyclic_level_mode_bit;

   // level mode waits for the host, pulse mode ends at half period
   wire cyc_clr = i_cyclic_level_mode_bit ? i_cyclic_flag_clear
                  : (cyc_half | cyc_adj_rel | ~cyc_on);

   rtc_flag #(
      .RST_VAL (rtc_pkg::FLAG_RST)
   ) u_cyc_flag (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_set  (cyc_bnd & ~cyc_adj_rel),
      .i_clr  (cyc_clr),
      .o_flag (o_cyclic_flag)
   );

   // alarm compare; disabling the alarm drops the request
   wire alarm_match = i_alarm_enable_bit & (i_cur_time == i_alarm_time);
   wire alarm_set   = alarm_match & ~match_d;
   wire alarm_clr   = i_alarm_flag_clear | ~i_alarm_enable_bit;

   rtc_flag #(
      .RST_VAL (rtc_pkg::FLAG_RST)
   ) u_alarm_flag (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_set  (alarm_set),
      .i_clr  (alarm_clr),
      .o_flag (o_alarm_flag)
   );

   // oscillator stop: count system clocks between crystal edges
   wire osc_stop_evt = (gap_cnt == GAP_W'(OSC_STOP_CYC - 1));

   rtc_flag #(
      .RST_VAL (rtc_pkg::OSC_STOP_RST)
   ) u_osc_flag (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_set  (osc_stop_evt),
      .i_clr  (i_osc_flag_clear),
      .o_flag (o_osc_stop_flag)
   );

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         xt_prev <= 1'b0;
         gap_cnt <= '0;
      end else begin
         xt_prev <= xt_sync;
         if (xt_sync != xt_prev) begin
            gap_cnt <= '0;
         end else if (gap_cnt != GAP_W'(OSC_STOP_CYC)) begin
            gap_cnt <= gap_cnt + GAP_W'(1);
         end
      end
   end

   // prescaler and second-of-minute divider
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pre     <= '0;
         sec_cnt <= '0;
      end else if (adj_start) begin
         pre[14:rtc_pkg::HZ8_BIT] <= '0;
         sec_cnt <= '0;
      end else if (tick_run) begin
         pre <= pre + 15'h0001;
         if (sec_wrap) begin
            sec_cnt <= sec_last ? 6'h00 : sec_cnt + 6'h01;
         end
      end
   end

   // seconds adjust sequence
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         adj_state         <= rtc_pkg::ADJ_IDLE;
         adj_cnt           <= '0;
         o_adjust_round_up <= 1'b0;
      end else begin
         o_adjust_round_up <= adj_start &
            (sec_cnt >= 6'(rtc_pkg::SEC_HALF_MIN));
         case (adj_state)
            rtc_pkg::ADJ_IDLE: begin
               adj_cnt <= '0;
               if (i_seconds_adjust_bit) begin
                  adj_state <= rtc_pkg::ADJ_BUSY;
               end
            end
            rtc_pkg::ADJ_BUSY: begin
               if (xt_tick) begin
                  if (adj_cnt == rtc_pkg::ADJ_XT - 3'h1) begin
                     adj_state <= rtc_pkg::ADJ_IDLE;
                  end
                  adj_cnt <= adj_cnt + 3'h1;
               end
            end
            default: begin
               adj_state <= rtc_pkg::ADJ_IDLE;
            end
         endcase
      end
   end

   // carry window and busy flag
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         carry_win         <= 1'b0;
         o_carry_busy_flag <= 1'b0;
         o_sec_carry       <= 1'b0;
      end else begin
         if (sec_wrap & i_count_enable_bit) begin
            carry_win <= 1'b1;
         end else if (xt_tick) begin
            carry_win <= 1'b0;
         end
         o_sec_carry       <= sec_wrap & i_count_enable_bit;
         o_carry_busy_flag <= carry_win | adj_busy | adj_start;
      end
   end

   // interrupt pin, open-drain, active low, independent of chip enable
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         match_d     <= 1'b0;
         o_irq_out_n <= 1'b0;
         o_irq_oe_n  <= 1'b1;
      end else begin
         match_d     <= alarm_match;
         o_irq_out_n <= 1'b0;
         o_irq_oe_n  <= ~(o_alarm_flag | o_cyclic_flag);
      end
   end

   // watchdog timer
   wire tmr_on = (i_timer_period_select != rtc_pkg::TMR_OFF);
   wire [15:0] tmr_last = (16'h0001 <<
      (5'(i_timer_period_select) + 5'(rtc_pkg::TMR_SHIFT))) - 16'h0001;
   wire tmr_expire = tmr_on & xt_tick & (tmr_cnt == tmr_last);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tmr_cnt           <= '0;
         tmr_pulse_cnt     <= '0;
         o_timer_pulse_out <= 1'b0;
         o_timer_flag      <= 1'b0;
      end else begin
         if (i_timer_restart_bit | ~tmr_on) begin
            tmr_cnt <= '0;
         end else if (tmr_expire) begin
            tmr_cnt <= '0;
         end else if (xt_tick) begin
            tmr_cnt <= tmr_cnt + 16'h0001;
         end
         if (i_timer_restart_bit) begin
            o_timer_pulse_out <= 1'b0;
            o_timer_flag      <= 1'b0;
            tmr_pulse_cnt     <= '0;
         end else if (tmr_expire) begin
            o_timer_pulse_out <= 1'b1;
            o_timer_flag      <= 1'b1;
            tmr_pulse_cnt     <= '0;
         end else if (o_timer_pulse_out & xt_tick) begin
            if (tmr_pulse_cnt == rtc_pkg::TMR_PULSE_XT - 4'h1) begin
               o_timer_pulse_out <= 1'b0;
               o_timer_flag      <= 1'b0;
            end
            tmr_pulse_cnt <= tmr_pulse_cnt + 4'h1;
         end
      end
   end

endmodule

// file: src/rtc_pkg.sv
// shared constants and types of the rtc interrupt and timer logic
package rtc_pkg;

   // time base
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned XT_HZ        = 32_768;
   localparam int unsigned PRE_W        = 15;
   localparam int unsigned SEC_PER_MIN  = 60;
   localparam int unsigned SEC_HALF_MIN = 30;

   // cyclic interrupt period select codes
   localparam logic [2:0] CYC_OFF   = 3'h0;
   localparam logic [2:0] CYC_488US = 3'h1;
   localparam logic [2:0] CYC_977US = 3'h2;
   localparam logic [2:0] CYC_7MS   = 3'h3;
   localparam logic [2:0] CYC_62MS  = 3'h4;
   localparam logic [2:0] CYC_1S    = 3'h5;
   localparam logic [2:0] CYC_60S   = 3'h6;

   // prescaler masks: period is mask+1 crystal ticks
   localparam logic [14:0] MASK_488US = 15'h000f;
   localparam logic [14:0] MASK_977US = 15'h001f;
   localparam logic [14:0] MASK_7MS   = 15'h00ff;
   localparam logic [14:0] MASK_62MS  = 15'h07ff;
   localparam logic [14:0] MASK_1S    = 15'h7fff;

   // 1 to 8 hz divider stages start at this prescaler bit
   localparam int unsigned HZ8_BIT = 11;

   // timer: period is 2**(select+TMR_SHIFT) crystal ticks, select 0 is off
   localparam logic [2:0]  TMR_OFF       = 3'h0;
   localparam int unsigned TMR_SHIFT     = 8;
   localparam logic [3:0]  TMR_PULSE_XT  = 4'h8;

   // seconds adjust busy time
   localparam longint unsigned ADJ_TIME_NS = 122_100;
   localparam logic [2:0] ADJ_XT =
      3'((ADJ_TIME_NS * XT_HZ) / 64'd1_000_000_000);

   // oscillator stop detection: no crystal edge for this long
   localparam longint unsigned OSC_STOP_TIME_NS = 250_000;
   localparam int unsigned OSC_STOP_CYC =
      int'((OSC_STOP_TIME_NS * CLK_HZ) / 64'd1_000_000_000);

   // reset values
   localparam logic OSC_STOP_RST = 1'b1;
   localparam logic FLAG_RST     = 1'b0;

   // bcd hours and minutes
   typedef struct packed {
      logic [5:0] hour;
      logic [6:0] minute;
   } rtc_hm_t;

   typedef enum logic [1:0] {
      ADJ_IDLE = 2'b01,
      ADJ_BUSY = 2'b10
   } rtc_adj_t;

endpackage

// file: src/rtc_sync3.sv
// three-stage synchroniser, output follows once stages two and three agree
`timescale 1ns/1ns
module rtc_sync3 (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_sync
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1     <= 1'b0;
         s2     <= 1'b0;
         s3     <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_sync <= s3;
         end
      end
   end
endmodule

// file: testbench/rtc_irq_timer_sva.sv
// assertions on the rtc interrupt and timer ports
`timescale 1ns/1ns
module rtc_irq_timer_sva #(
   parameter int unsigned OSC_STOP_CYC = 200
) (
   input wire logic             i_clk,
   input wire logic             i_rst,
   input wire logic             i_xtal,
   input wire logic             i_alarm_enable_bit,
   input wire rtc_pkg::rtc_hm_t i_alarm_time,
   input wire rtc_pkg::rtc_hm_t i_cur_time,
   input wire logic             i_alarm_flag_clear,
   input wire logic [2:0]       i_cyclic_sel,
   input wire logic             i_cyclic_level_mode_bit,
   input wire logic             i_cyclic_flag_clear,
   input wire logic             i_timer_restart_bit,
   input wire logic             i_seconds_adjust_bit,
   input wire logic             o_irq_out_n,
   input wire logic             o_irq_oe_n,
   input wire logic             o_alarm_flag,
   input wire logic             o_cyclic_flag,
   input wire logic             o_timer_pulse_out,
   input wire logic             o_timer_flag,
   input wire logic             o_osc_stop_flag,
   input wire logic             o_carry_busy_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire         match = i_alarm_enable_bit && (i_alarm_time == i_cur_time);
   logic [15:0] still;
   logic        xt_q;
   // raw crystal quiet time, saturating
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         still <= 16'h0000;
         xt_q  <= 1'b0;
      end else begin
         xt_q <= i_xtal;
         if (i_xtal != xt_q) still <= 16'h0000;
         else if (still != 16'hffff) still <= still + 16'h0001;
      end
   end
   sequence busy_run;
      o_carry_busy_flag [*8];
   endsequence
   irq_low_a: assert property (o_irq_out_n == 1'b0)
      else $error("irq data not low");
   irq_or_a: assert property (o_irq_oe_n == !($past(o_alarm_flag) || $past(o_cyclic_flag)))
      else $error("irq enable not the or of flags");
   timer_flag_a: assert property (o_timer_flag == o_timer_pulse_out)
      else $error("timer flag differs from pulse");
   restart_cut_a: assert property (i_timer_restart_bit |=> !o_timer_pulse_out)
      else $error("timer pulse not cut by restart");
   alarm_set_a: assert property ($rose(match) |=> o_alarm_flag)
      else $error("alarm flag not set on match");
   alarm_clr_a: assert property (i_alarm_flag_clear && !$rose(match) |=> !o_alarm_flag)
      else $error("alarm flag not cleared");
   level_hold_a: assert property (o_cyclic_flag && i_cyclic_level_mode_bit
      && !i_cyclic_flag_clear && i_cyclic_sel != 3'h0 && i_cyclic_sel != 3'h7
      |=> o_cyclic_flag)
      else $error("level cyclic flag dropped");
   adjust_busy_a: assert property (i_seconds_adjust_bit && !o_carry_busy_flag |=> busy_run)
      else $error("busy not held during adjust");
   osc_stop_a: assert property (still == 16'(OSC_STOP_CYC + 8) |-> o_osc_stop_flag)
      else $error("oscillator stop not flagged");
endmodule

bind rtc_irq_timer rtc_irq_timer_sva #(.OSC_STOP_CYC(OSC_STOP_CYC)) chk_u (.i_clk, .i_rst,
   .i_xtal, .i_alarm_enable_bit, .i_alarm_time, .i_cur_time, .i_alarm_flag_clear,
   .i_cyclic_sel, .i_cyclic_level_mode_bit, .i_cyclic_flag_clear, .i_timer_restart_bit,
   .i_seconds_adjust_bit, .o_irq_out_n, .o_irq_oe_n, .o_alarm_flag, .o_cyclic_flag,
   .o_timer_pulse_out, .o_timer_flag, .o_osc_stop_flag, .o_carry_busy_flag);

// file: testbench/rtc_irq_timer_test.sv
// self-checking bench for the rtc interrupt and timer logic
`timescale 1ns/1ns
module rtc_irq_timer_test;
   logic             i_clk    = 1'b0;
   logic             i_rst    = 1'b1;
   logic             run      = 1'b1;
   logic             cnt_en   = 1'b1;
   logic             al_en    = 1'b0;
   rtc_pkg::rtc_hm_t al_t     = '0;
   rtc_pkg::rtc_hm_t cur_t    = '0;
   logic [2:0]       cyc      = 3'h0;
   logic             lvl      = 1'b0;
   logic [2:0]       tsel     = 3'h0;
   logic [4:0]       pv       = 5'h00;
   logic [14:0]      m [3]    = '{rtc_pkg::MASK_488US, rtc_pkg::MASK_977US, rtc_pkg::MASK_7MS};
   wire              xtal;
   wire              oe_n;
   wire              tflag;
   wire  [4:0]       ov;
   int               failures = 0;
   int               checks   = 0;
   int               n;
   int               n1;
   always #10 i_clk = ~i_clk;
   rtc_xtal_model xt_u (.i_run(run), .o_xtal(xtal));
   rtc_irq_timer #(.OSC_STOP_CYC(200)) dut_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_xtal(xtal), .i_alarm_enable_bit(al_en),
      .i_alarm_time(al_t), .i_cur_time(cur_t), .i_alarm_flag_clear(pv[0]),
      .i_cyclic_sel(cyc), .i_cyclic_level_mode_bit(lvl), .i_cyclic_flag_clear(pv[1]),
      .i_timer_period_select(tsel), .i_timer_restart_bit(pv[2]),
      .i_seconds_adjust_bit(pv[3]), .i_count_enable_bit(cnt_en), .i_osc_flag_clear(pv[4]),
      .o_irq_out_n(), .o_irq_oe_n(oe_n), .o_alarm_flag(ov[0]), .o_cyclic_flag(ov[1]),
      .o_timer_pulse_out(ov[2]), .o_timer_flag(tflag), .o_osc_stop_flag(ov[4]),
      .o_carry_busy_flag(ov[3]), .o_sec_carry(), .o_adjust_round_up());
   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_n(input string what, input int exp, input int got);
      checks++;
      if (got != exp) begin
         failures++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic strobe(input int k);
      pv[k] = 1'b1;
      tick(1);
      pv[k] = 1'b0;
      tick(1);
   endtask
   task automatic wait_bit(input int k, input logic v, input int lim);
      n = 0;
      while (ov[k] !== v) begin
         if (n == lim) begin
            failures++;
            $display("BAD wait on output %0d expected %b seen %b", k, v, ov[k]);
            finish_test();
         end else begin
            tick(1);
            n++;
         end
      end
   endtask
   initial begin
      tick(3);
      i_rst = 1'b0;
      chk("osc stop after reset", 1'b1, ov[4]);
      chk("irq released after reset", 1'b1, oe_n);
      tick(2);
      strobe(4);
      chk("osc stop cleared", 1'b0, ov[4]);
      run = 1'b0;
      wait_bit(4, 1'b1, 400);
      tick(20);
      run = 1'b1;
      tick(50);
      strobe(4);
      tick(50);
      chk("osc stop stays clear", 1'b0, ov[4]);
      $display("test osc done");
      al_en = 1'b0;
      al_t = '{hour: 6'h12, minute: 7'h34};
      cur_t = '{hour: 6'h12, minute: 7'h33};
      tick(1);
      al_en = 1'b1;
      tick(3);
      chk("alarm idle", 1'b0, ov[0]);
      cur_t.minute = 7'h34;
      wait_bit(0, 1'b1, 3);
      tick(1);
      chk("irq on alarm", 1'b0, oe_n);
      strobe(0);
      chk("alarm cleared", 1'b0, ov[0]);
      chk("irq off after clear", 1'b1, oe_n);
      $display("test alarm done");
      for (int k = 0; k < 3; k++) begin
         cyc = 3'(k + 1);
         wait_bit(1, 1'b1, 3000);
         wait_bit(1, 1'b0, 3000);
         n1 = n;
         wait_bit(1, 1'b1, 3000);
         chk_n("cyclic period", (int'(m[k]) + 1) * 8, n1 + n);
         chk_n("cyclic pulse width", (int'(m[k]) + 1) * 4, n1);
         cyc = rtc_pkg::CYC_OFF;
         tick(3);
         chk("cyclic off", 1'b0, ov[1]);
      end
      lvl = 1'b1;
      cyc = rtc_pkg::CYC_488US;
      wait_bit(1, 1'b1, 300);
      tick(300);
      chk("level flag held", 1'b1, ov[1]);
      cur_t.minute = 7'h33;
      tick(1);
      cur_t.minute = 7'h34;
      tick(2);
      strobe(1);
      chk("level flag cleared", 1'b0, ov[1]);
      chk("irq or of sources", 1'b0, oe_n);
      al_en = 1'b0;
      cyc = rtc_pkg::CYC_OFF;
      tick(3);
      chk("irq off", 1'b1, oe_n);
      $display("test cyclic done");
      tsel = 3'h1;
      wait_bit(2, 1'b1, 5000);
      chk("timer flag", 1'b1, tflag);
      strobe(2);
      chk("timer pulse cut", 1'b0, ov[2]);
      tick(2000);
      strobe(2);
      wait_bit(2, 1'b1, 5000);
      chk("restart delays expiry", 1'b1, n > 4000);
      tsel = rtc_pkg::TMR_OFF;
      $display("test timer done");
      cnt_en = 1'b0;
      tick(2);
      chk("busy low before write", 1'b0, ov[3]);
      strobe(3);
      chk("busy on adjust", 1'b1, ov[3]);
      wait_bit(3, 1'b0, 100);
      chk("adjust busy span", 1'b1, n >= 20 && n <= 40);
      $display("test adjust done");
      finish_test();
   end
endmodule

// file: testbench/rtc_xtal_model.sv
// crystal source that can be stopped, fast for simulation
`timescale 1ns/1ns
module rtc_xtal_model (
   input  wire logic i_run,
   output logic      o_xtal
);
   initial o_xtal = 1'b0;
   always begin
      #80;
      if (i_run) o_xtal = ~o_xtal;
   end
endmodule
